/* rpcc_addr_match.sv */
// incoming packet address compare against the own match word
`timescale 1ns/10ps
`default_nettype none
module rpcc_addr_match (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // configuration
  input  wire logic [31:0] own,
  input  wire logic [2:0]  width,
  input  wire logic        len_ok,
  // packet address
  input  wire logic [31:0] pkt_addr,
  input  wire logic        pkt_valid,
  // result pulses
  output logic             hit,
  output logic             miss
);

  typedef struct packed {
    logic hit;
    logic miss;
  } rpcc_match_state_t;

  rpcc_match_state_t st;
  rpcc_match_state_t next_st;

  always_comb
  begin
    logic [3:0] mask;
    logic       same;
    mask = rpcc_pkg::match_mask(width);
    same = 1'b1;
    for (int b = 0; b < 4; b++)
      if (mask[b] && (own[8*b +: 8] != pkt_addr[8*b +: 8]))
        same = 1'b0;
    // an empty mask or bad length never accepts
    next_st.hit  = pkt_valid && same && (mask != 4'h0) && len_ok;
    next_st.miss = pkt_valid && !next_st.hit;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign hit  = st.hit;
  assign miss = st.miss;

endmodule : rpcc_addr_match
`default_nettype wire

/* rpcc_clk_div.sv */
// core clock tick generator from the rate and source selects
`timescale 1ns/10ps
`default_nettype none
module rpcc_clk_div (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // selects
  input  wire logic [1:0] rate,
  input  wire logic       source,
  // tick
  output logic            tick
);

  typedef struct packed {
    logic [8:0] cnt;
    logic       tick;
  } rpcc_div_state_t;

  rpcc_div_state_t st;
  rpcc_div_state_t next_st;

  function automatic logic [8:0] div_of(input logic [1:0] r);
    case (r)
      2'h0:    div_of = rpcc_pkg::DIV_4M;
      2'h1:    div_of = rpcc_pkg::DIV_2M;
      2'h2:    div_of = rpcc_pkg::DIV_1M;
      default: div_of = rpcc_pkg::DIV_500K;
    endcase
  endfunction : div_of

  always_comb
  begin
    next_st = st;
    if (source)
    begin
      // direct source: tick every cycle
      next_st.cnt  = 9'h000;
      next_st.tick = 1'b1;
    end
    else if (st.cnt >= div_of(rate) - 9'h001)
    begin
      // >= so a rate change to a faster setting restarts at once
      next_st.cnt  = 9'h000;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.cnt  = st.cnt + 9'h001;
      next_st.tick = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

endmodule : rpcc_clk_div
`default_nettype wire

/* rpcc_pkg.sv */
// constants and shared decode for the payload, match and core clock registers
package rpcc_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_RX_LEN = 8'h00;
  localparam logic [7:0] OFF_TX_LEN = 8'h04;
  localparam logic [7:0] OFF_MATCH  = 8'h08;
  localparam logic [7:0] OFF_CLKCFG = 8'h0c;
  localparam logic [7:0] OFF_WIDTH  = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CLKCFG_RATE_LSB = 0;
  localparam int CLKCFG_SRC_BIT  = 2;
  localparam int STAT_RX_OK_BIT  = 0;
  localparam int STAT_TX_OK_BIT  = 1;
  localparam int STAT_WIDTH_BIT  = 2;
  localparam int STAT_MASK_LSB   = 4;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [5:0]  PLEN_RESET  = 6'h20;
  localparam logic [5:0]  PLEN_MAX    = 6'h20;
  localparam logic [31:0] MATCH_RESET = 32'he7e7e7e7;
  localparam logic [1:0]  RATE_RESET  = 2'h0;
  localparam logic        SRC_RESET   = 1'b0;
  localparam logic [2:0]  WIDTH_1B    = 3'h1;
  localparam logic [2:0]  WIDTH_4B    = 3'h4;
  localparam logic [2:0]  WIDTH_RESET = 3'h4;
  localparam logic [3:0]  MASK_RESET  = 4'hf;

  // ----------------------------------------------------------------
  // core clock rates and derived divide counts
  // ----------------------------------------------------------------
  localparam int CLK_KHZ     = 200000;
  localparam int RATE_4M_KHZ = 4000;
  localparam int RATE_2M_KHZ = 2000;
  localparam int RATE_1M_KHZ = 1000;
  localparam int RATE_500K_KHZ = 500;
  localparam logic [8:0] DIV_4M   = 9'(CLK_KHZ / RATE_4M_KHZ);
  localparam logic [8:0] DIV_2M   = 9'(CLK_KHZ / RATE_2M_KHZ);
  localparam logic [8:0] DIV_1M   = 9'(CLK_KHZ / RATE_1M_KHZ);
  localparam logic [8:0] DIV_500K = 9'(CLK_KHZ / RATE_500K_KHZ);

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ACCESS = 2'b10
  } rpcc_bus_st_t;

  // bytes of the own match word taken part in comparison, low byte first
  function automatic logic [3:0] match_mask(input logic [2:0] width);
    case (width)
      3'h1:    match_mask = 4'h1;
      3'h2:    match_mask = 4'h3;
      3'h3:    match_mask = 4'h7;
      3'h4:    match_mask = 4'hf;
      default: match_mask = 4'h0;
    endcase
  endfunction : match_mask

endpackage : rpcc_pkg

/* rpcc_top.sv */
// payload length, own match and core clock configuration bank on APB
//
// Contract
// - The receive payload length is a binary byte count, 1 to 32.
// - The transmit payload length is a binary byte count, 1 to 32.
// - The transmit payload length resets to 32 bytes.
// - The own match word resets to e7e7e7e7 and only selected bytes are compared.
// - The core clock rate code 0,1,2,3 gives 4 MHz, 2 MHz, 1 MHz, 500 kHz.
// - The core clock rate resets to code 0, 4 MHz.
// - The core clock source select is one bit that resets to 0.
// - With source 0 the processor runs at the selected rate.
// - The receive payload length resets to 32 bytes.
// - Match width code 1 means one byte and code 4 means four bytes.
`timescale 1ns/10ps
`default_nettype none
module rpcc_top (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // packet shape
  output logic [5:0]       RX_PAYLOAD_LENGTH,
  output logic [5:0]       TX_PAYLOAD_LENGTH,
  output logic             RX_LEN_VALID,
  output logic             TX_LEN_VALID,
  // own match
  output logic [31:0]      OWN_RECEIVE_MATCH,
  output logic [3:0]       MATCH_BYTE_EN,
  input  wire logic [31:0] PKT_ADDR,
  input  wire logic        PKT_ADDR_VALID,
  output logic             PKT_ADDR_HIT,
  output logic             PKT_ADDR_MISS,
  // core clock
  output logic [1:0]       CORE_CLOCK_RATE,
  output logic             CORE_CLOCK_SOURCE,
  output logic             CORE_CLK_TICK
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rpcc_pkg::rpcc_bus_st_t bus;
    logic                   ready;
    logic                   slverr;
    logic [31:0]            rdata;
    logic [5:0]             rx_len;
    logic [5:0]             tx_len;
    logic [31:0]            match;
    logic [2:0]             width;
    logic [1:0]             rate;
    logic                   source;
    logic                   rx_ok;
    logic                   tx_ok;
    logic [3:0]             byte_en;
  } rpcc_top_state_t;

  localparam rpcc_top_state_t RESET_STATE = '{
    bus:     rpcc_pkg::BUS_IDLE,
    ready:   1'b0,
    slverr:  1'b0,
    rdata:   32'h0000_0000,
    rx_len:  rpcc_pkg::PLEN_RESET,
    tx_len:  rpcc_pkg::PLEN_RESET,
    match:   rpcc_pkg::MATCH_RESET,
    width:   rpcc_pkg::WIDTH_RESET,
    rate:    rpcc_pkg::RATE_RESET,
    source:  rpcc_pkg::SRC_RESET,
    rx_ok:   1'b1,
    tx_ok:   1'b1,
    byte_en: rpcc_pkg::MASK_RESET
  };

  rpcc_top_state_t st;
  rpcc_top_state_t next_st;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // a byte count of 1..32; 0 and 33..63 are refused
  function automatic logic len_ok(input logic [5:0] len);
    len_ok = (len != 6'h00) && (len <= rpcc_pkg::PLEN_MAX);
  endfunction : len_ok

  function automatic logic mapped(input logic [7:0] addr);
    case (addr)
      rpcc_pkg::OFF_RX_LEN,
      rpcc_pkg::OFF_TX_LEN,
      rpcc_pkg::OFF_MATCH,
      rpcc_pkg::OFF_CLKCFG,
      rpcc_pkg::OFF_WIDTH,
      rpcc_pkg::OFF_STATUS: mapped = 1'b1;
      default:              mapped = 1'b0;
    endcase
  endfunction : mapped

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (PADDR)
      rpcc_pkg::OFF_RX_LEN:
        rd_word[5:0] = st.rx_len;
      rpcc_pkg::OFF_TX_LEN:
        rd_word[5:0] = st.tx_len;
      rpcc_pkg::OFF_MATCH:
        rd_word = st.match;
      rpcc_pkg::OFF_CLKCFG:
      begin
        rd_word[rpcc_pkg::CLKCFG_RATE_LSB +: 2] = st.rate;
        rd_word[rpcc_pkg::CLKCFG_SRC_BIT]       = st.source;
      end
      rpcc_pkg::OFF_WIDTH:
        rd_word[2:0] = st.width;
      rpcc_pkg::OFF_STATUS:
      begin
        rd_word[rpcc_pkg::STAT_RX_OK_BIT]      = st.rx_ok;
        rd_word[rpcc_pkg::STAT_TX_OK_BIT]      = st.tx_ok;
        rd_word[rpcc_pkg::STAT_WIDTH_BIT]      = (st.byte_en != 4'h0);
        rd_word[rpcc_pkg::STAT_MASK_LSB +: 4]  = st.byte_en;
      end
      default:
        rd_word = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // bus and register update
  // ----------------------------------------------------------------
  always_comb
  begin
    logic wr_en;
    wr_en   = 1'b0;
    next_st = st;
    case (st.bus)
      rpcc_pkg::BUS_IDLE:
      begin
        // answer is prepared in the setup cycle: zero wait states
        if (PSEL && !PENABLE)
        begin
          next_st.bus    = rpcc_pkg::BUS_ACCESS;
          next_st.ready  = 1'b1;
          next_st.slverr = !mapped(PADDR);
          next_st.rdata  = PWRITE ? 32'h0000_0000 : rd_word;
        end
      end
      rpcc_pkg::BUS_ACCESS:
      begin
        // write lands only on the completing access edge
        wr_en          = PSEL && PENABLE && st.ready && PWRITE && mapped(PADDR);
        next_st.bus    = rpcc_pkg::BUS_IDLE;
        next_st.ready  = 1'b0;
        next_st.slverr = 1'b0;
        next_st.rdata  = 32'h0000_0000;
      end
      default:
      begin
        next_st.bus    = rpcc_pkg::BUS_IDLE;
        next_st.ready  = 1'b0;
        next_st.slverr = 1'b0;
      end
    endcase

    if (wr_en)
    begin
      case (PADDR)
        rpcc_pkg::OFF_RX_LEN:
          next_st.rx_len = PWDATA[5:0];
        rpcc_pkg::OFF_TX_LEN:
          next_st.tx_len = PWDATA[5:0];
        rpcc_pkg::OFF_MATCH:
          next_st.match = PWDATA;
        rpcc_pkg::OFF_CLKCFG:
        begin
          // processor special register mirror is software's job
          next_st.rate   = PWDATA[rpcc_pkg::CLKCFG_RATE_LSB +: 2];
          next_st.source = PWDATA[rpcc_pkg::CLKCFG_SRC_BIT];
        end
        rpcc_pkg::OFF_WIDTH:
          next_st.width = PWDATA[2:0];
        default:
          next_st.width = st.width;
      endcase
    end

    // flags follow the stored values in the same cycle
    next_st.rx_ok   = len_ok(next_st.rx_len);
    next_st.tx_ok   = len_ok(next_st.tx_len);
    next_st.byte_en = rpcc_pkg::match_mask(next_st.width);
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      st <= RESET_STATE;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // packet address compare
  // ----------------------------------------------------------------
  rpcc_addr_match u_match (
    .clk       (CLK),
    .rst_n     (RST_N),
    .own       (st.match),
    .width     (st.width),
    .len_ok    (st.rx_ok),
    .pkt_addr  (PKT_ADDR),
    .pkt_valid (PKT_ADDR_VALID),
    .hit       (PKT_ADDR_HIT),
    .miss      (PKT_ADDR_MISS)
  );

  // ----------------------------------------------------------------
  // core clock tick
  // ----------------------------------------------------------------
  rpcc_clk_div u_div (
    .clk    (CLK),
    .rst_n  (RST_N),
    .rate   (st.rate),
    .source (st.source),
    .tick   (CORE_CLK_TICK)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PREADY            = st.ready;
  assign PRDATA            = st.rdata;
  assign PSLVERR           = st.slverr;
  assign RX_PAYLOAD_LENGTH = st.rx_len;
  assign TX_PAYLOAD_LENGTH = st.tx_len;
  assign RX_LEN_VALID      = st.rx_ok;
  assign TX_LEN_VALID      = st.tx_ok;
  assign OWN_RECEIVE_MATCH = st.match;
  assign MATCH_BYTE_EN     = st.byte_en;
  assign CORE_CLOCK_RATE   = st.rate;
  assign CORE_CLOCK_SOURCE = st.source;

endmodule : rpcc_top
`default_nettype wire

/* rpcc_top_properties.sv */
// port assertions for the payload, match and core clock register bank
`timescale 1ns/10ps
`default_nettype none
module rpcc_top_props (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  // packet shape and match
  input wire logic [5:0]  RX_PAYLOAD_LENGTH,
  input wire logic [5:0]  TX_PAYLOAD_LENGTH,
  input wire logic        RX_LEN_VALID,
  input wire logic        TX_LEN_VALID,
  input wire logic [31:0] OWN_RECEIVE_MATCH,
  input wire logic [3:0]  MATCH_BYTE_EN,
  input wire logic [31:0] PKT_ADDR,
  input wire logic        PKT_ADDR_VALID,
  input wire logic        PKT_ADDR_HIT,
  input wire logic        PKT_ADDR_MISS,
  // core clock
  input wire logic [1:0]  CORE_CLOCK_RATE,
  input wire logic        CORE_CLOCK_SOURCE,
  input wire logic        CORE_CLK_TICK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [9:0]  gap;
  logic        seen;
  logic        chg;
  logic [1:0]  rate_q;
  logic [31:0] wd_q;
  logic        wr;
  logic        ok;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  assign ok = RX_LEN_VALID && (MATCH_BYTE_EN != 4'h0) && (((PKT_ADDR ^ OWN_RECEIVE_MATCH)
    & {{8{MATCH_BYTE_EN[3]}}, {8{MATCH_BYTE_EN[2]}}, {8{MATCH_BYTE_EN[1]}},
    {8{MATCH_BYTE_EN[0]}}}) == 32'h0);
  // a rate change or a high source select spoils the interval it falls in
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      gap <= 10'h0;
      seen <= 1'b0;
      chg <= 1'b0;
      rate_q <= 2'h0;
      wd_q <= 32'h0;
    end
    else
    begin
      gap <= CORE_CLK_TICK ? 10'h0 : gap + 10'h1;
      seen <= seen | CORE_CLK_TICK;
      chg <= CORE_CLK_TICK ? 1'b0 : chg | (CORE_CLOCK_RATE != rate_q) | CORE_CLOCK_SOURCE;
      rate_q <= CORE_CLOCK_RATE;
      wd_q <= PWDATA;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_rx_len_valid: assert property (
    RX_LEN_VALID == (RX_PAYLOAD_LENGTH inside {[6'h01:6'h20]}))
    else $error("rx length valid flag wrong");
  a_tx_len_valid: assert property (
    TX_LEN_VALID == (TX_PAYLOAD_LENGTH inside {[6'h01:6'h20]}))
    else $error("tx length valid flag wrong");
  a_rx_len_write: assert property (
    wr && PADDR == rpcc_pkg::OFF_RX_LEN |=> RX_PAYLOAD_LENGTH == wd_q[5:0])
    else $error("rx length not written");
  a_tx_len_write: assert property (
    wr && PADDR == rpcc_pkg::OFF_TX_LEN |=> TX_PAYLOAD_LENGTH == wd_q[5:0])
    else $error("tx length not written");
  a_clk_cfg_write: assert property (
    wr && PADDR == rpcc_pkg::OFF_CLKCFG
      |=> CORE_CLOCK_RATE == wd_q[1:0] && CORE_CLOCK_SOURCE == wd_q[2])
    else $error("core clock select not written");
  a_match_hit: assert property (
    PKT_ADDR_VALID && ok |=> PKT_ADDR_HIT && !PKT_ADDR_MISS)
    else $error("expected address hit");
  a_match_miss: assert property (
    PKT_ADDR_VALID && !ok |=> PKT_ADDR_MISS && !PKT_ADDR_HIT)
    else $error("expected address miss");
  a_match_quiet: assert property (
    !PKT_ADDR_VALID |=> !PKT_ADDR_HIT && !PKT_ADDR_MISS)
    else $error("compare result without strobe");
  a_tick_spacing: assert property (
    CORE_CLK_TICK && seen && !chg && !CORE_CLOCK_SOURCE && CORE_CLOCK_RATE == rate_q
      |-> gap == (10'd50 << CORE_CLOCK_RATE) - 10'd1)
    else $error("core tick spacing wrong");
  a_direct_tick: assert property (
    CORE_CLOCK_SOURCE [*3] |-> CORE_CLK_TICK)
    else $error("direct source tick missing");
endmodule : rpcc_top_props
bind rpcc_top rpcc_top_props u_rpcc_top_props (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .RX_PAYLOAD_LENGTH(RX_PAYLOAD_LENGTH), .TX_PAYLOAD_LENGTH(TX_PAYLOAD_LENGTH),
  .RX_LEN_VALID(RX_LEN_VALID), .TX_LEN_VALID(TX_LEN_VALID),
  .OWN_RECEIVE_MATCH(OWN_RECEIVE_MATCH), .MATCH_BYTE_EN(MATCH_BYTE_EN), .PKT_ADDR(PKT_ADDR),
  .PKT_ADDR_VALID(PKT_ADDR_VALID), .PKT_ADDR_HIT(PKT_ADDR_HIT), .PKT_ADDR_MISS(PKT_ADDR_MISS),
  .CORE_CLOCK_RATE(CORE_CLOCK_RATE), .CORE_CLOCK_SOURCE(CORE_CLOCK_SOURCE),
  .CORE_CLK_TICK(CORE_CLK_TICK));
`default_nettype wire

/* rpcc_top_tb_top.sv */
// self-checking bench for the payload, match and core clock register bank
`timescale 1ns/10ps
`default_nettype none
module rpcc_top_tb_top;
  logic        clk, rst_n, psel, penable, pwrite, pvld, pready, pslverr, rx_ok, tx_ok;
  logic        hit, miss, src, tick, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, paddr_pkt, own, rd;
  logic [5:0]  rx_len, tx_len, v;
  logic [3:0]  byte_en;
  logic [1:0]  rate;
  int          failures, checks_done;
  logic [7:0]  ra [6] = '{rpcc_pkg::OFF_RX_LEN, rpcc_pkg::OFF_TX_LEN, rpcc_pkg::OFF_MATCH,
                         rpcc_pkg::OFF_CLKCFG, rpcc_pkg::OFF_WIDTH, rpcc_pkg::OFF_STATUS};
  logic [31:0] rv [6] = '{32'h20, 32'h20, 32'he7e7e7e7, 32'h0, 32'h4, 32'hf7};
  logic [5:0]  lens [6] = '{6'h01, 6'h02, 6'h20, 6'h00, 6'h21, 6'h3f};
  rpcc_top u_rpcc_top (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .RX_PAYLOAD_LENGTH(rx_len), .TX_PAYLOAD_LENGTH(tx_len),
    .RX_LEN_VALID(rx_ok), .TX_LEN_VALID(tx_ok), .OWN_RECEIVE_MATCH(own),
    .MATCH_BYTE_EN(byte_en), .PKT_ADDR(paddr_pkt), .PKT_ADDR_VALID(pvld),
    .PKT_ADDR_HIT(hit), .PKT_ADDR_MISS(miss), .CORE_CLOCK_RATE(rate),
    .CORE_CLOCK_SOURCE(src), .CORE_CLK_TICK(tick));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic bound(input int n);
    if (n >= 1000)
    begin
      failures++;
      test_done();
    end
  endtask : bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 1000);
    bound(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pkt(input logic [31:0] a, input logic exp_hit);
    @(posedge clk);
    paddr_pkt <= a;
    pvld <= 1'b1;
    @(posedge clk);
    pvld <= 1'b0;
    @(posedge clk);
    chk("hit", {31'h0, exp_hit}, {31'h0, hit});
    chk("miss", {31'h0, !exp_hit}, {31'h0, miss});
  endtask : pkt
  // waits out one tick, then counts edges to the next one
  task automatic tick_gap(input int exp);
    int n;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (tick !== 1'b1 && n < 1000);
      bound(n);
    end
    chk("tick gap", exp, n);
  endtask : tick_gap
  // ----------------------------------------------------------------
  // clock and sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, pvld} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    paddr_pkt = 32'h0;
    failures = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("len ports", 32'h2020, {18'h0, tx_len, 2'h0, rx_len});
    chk("match port", 32'he7e7e7e7, own);
    chk("clock ports", 32'h0, {29'h0, src, rate});
    chk("byte enables", 32'hf, {28'h0, byte_en});
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset reg", rv[i], rd);
    end
    $display("test reset done");
    foreach (lens[i])
    begin
      v = 6'h21 - lens[i];
      apb(1'b1, rpcc_pkg::OFF_RX_LEN, {26'h0, lens[i]});
      apb(1'b1, rpcc_pkg::OFF_TX_LEN, {26'h0, v});
      apb(1'b0, rpcc_pkg::OFF_RX_LEN, 32'h0);
      chk("rx len reg", {26'h0, lens[i]}, rd);
      apb(1'b0, rpcc_pkg::OFF_TX_LEN, 32'h0);
      chk("tx len reg", {26'h0, v}, rd);
      chk("rx valid", {31'h0, lens[i] != 6'h0 && lens[i] <= 6'h20}, {31'h0, rx_ok});
      chk("tx valid", {31'h0, v != 6'h0 && v <= 6'h20}, {31'h0, tx_ok});
    end
    $display("test lengths done");
    pkt(32'he7e7e7e7, 1'b0);
    apb(1'b1, rpcc_pkg::OFF_RX_LEN, 32'h4);
    apb(1'b1, 8'h01, 32'h5);
    chk("misaligned error", 32'h1, {31'h0, err});
    chk("rx len kept", 32'h4, {26'h0, rx_len});
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped read", 32'h0, rd);
    apb(1'b1, rpcc_pkg::OFF_MATCH, 32'h11223344);
    apb(1'b1, rpcc_pkg::OFF_WIDTH, 32'h1);
    // the write lands on the access edge; let it settle before looking
    @(posedge clk);
    chk("byte enables", 32'h1, {28'h0, byte_en});
    pkt(32'haabbcc44, 1'b1);
    pkt(32'h11223345, 1'b0);
    apb(1'b1, rpcc_pkg::OFF_WIDTH, 32'h2);
    pkt(32'haabb3344, 1'b1);
    pkt(32'haabb3244, 1'b0);
    apb(1'b1, rpcc_pkg::OFF_WIDTH, 32'h0);
    @(posedge clk);
    chk("byte enables", 32'h0, {28'h0, byte_en});
    pkt(32'h11223344, 1'b0);
    apb(1'b1, rpcc_pkg::OFF_WIDTH, 32'h4);
    apb(1'b0, rpcc_pkg::OFF_WIDTH, 32'h0);
    chk("width reg", 32'h4, rd);
    chk("byte enables", 32'hf, {28'h0, byte_en});
    pkt(32'h11223344, 1'b1);
    pkt(32'h01223344, 1'b0);
    apb(1'b0, rpcc_pkg::OFF_STATUS, 32'h0);
    chk("status reg", 32'hf5, rd);
    $display("test match done");
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b1, rpcc_pkg::OFF_CLKCFG, r);
      tick_gap(50 << r);
    end
    apb(1'b1, rpcc_pkg::OFF_CLKCFG, 32'h4);
    apb(1'b0, rpcc_pkg::OFF_CLKCFG, 32'h0);
    chk("clock reg", 32'h4, rd);
    repeat (3)
    begin
      @(posedge clk);
      chk("direct tick", 32'h1, {31'h0, tick});
    end
    $display("test clock done");
    test_done();
  end
endmodule : rpcc_top_tb_top
`default_nettype wire
